// ---- src/pwm_timer_bank.v ----
// eight down-counting pwm timer channels behind an avalon-mm slave
// What this block does
// R1: counter loads reload buffer on update or auto-reload
// R2: compare buffer copied to working compare likewise
// R3: observe register returns live counter, ignores writes
// R4: reload buffer reads stored value, not counter
// R5: buffer writes only act at next load
// R6: one-shot: counter halts after reaching zero
// R7: repeat and pattern run repeat count plus one
// R8: repeat count end raises the channel interrupt
// R9: 128-bit pattern in four words, word 0 low
// R10: pattern emits length plus one bits
// R11: id register names lowest pending timer 1..8
// R12: output low on update or auto-reload
// R13: output high when counter equals compare
// R14: inverter flips the output sense outside pattern mode
// R15: software may rewrite compare any time
// R16: dead zone gives gapped true and complement
// R17: gap is dead-zone setting cycles when ticking on the bus clock
// R18: setting zero or one disables the gap
// R19: software keeps dead zone below compare
// R20: dma mode requests at each count end
// R21: request held until acknowledge drops it
// R22: dma mode suppresses the interrupt
// R23: mode field picks one-shot, interval, repeat, pattern
// R24: load request bit self-clears after use
// R25: interrupt level until cleared, or pulse
// R26: counter decrements per selected clock tick
// R27: pattern shifts one bit per period from bit 0
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`include "pwm_timer_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pwm_timer_bank #(
    parameter        CH       = 8,             // sizes the flattened views; the channel count is fixed at 8
    parameter [31:0] REVISION = 32'h00000001   // arbitrary revision value
) (
    input  wire        clock_in,
    input  wire        rst_in,
    input  wire [9:0]  address_in,             // byte address
    input  wire        read_in,
    input  wire        write_in,
    input  wire [31:0] writedata_in,
    input  wire [3:0]  byteenable_in,
    output wire [31:0] readdata_out,
    output wire        waitrequest_out,
    input  wire        ext_clk_in,             // external timer clock pin
    input  wire [7:0]  dma_acknowledge_in,     // from dma controller, same clock
    output wire [7:0]  dma_request_out,
    output wire        irq_out,
    output wire [7:0]  pwm_out,
    output wire [7:0]  pwm_out_inverse,
    output wire [7:0]  pwm_out_gapped,
    output wire [7:0]  pwm_out_inverse_gapped
);

    // bus answer registers
    reg  [31:0]     rdata_reg;                 // latched read data
    reg             wait_reg;                  // waitrequest, high when idle
    reg  [31:0]     rdata_next;                // read mux result
    // global state
    reg  [7:0]      start_reg;                 // per-channel start bits
    reg  [3:0]      id_reg;                    // pending timer id
    reg  [3:0]      id_next;
    reg             irq_reg;                   // combined interrupt line
    // external clock synchroniser and edge detector
    reg             ext_s1_reg;
    reg             ext_s2_reg;
    reg             ext_s3_reg;
    // flattened per-channel views for the read mux
    wire [CH*32-1:0]  ctrl_all;
    wire [CH*32-1:0]  rel_all;
    wire [CH*32-1:0]  cmp_all;
    wire [CH*32-1:0]  cnt_all;
    wire [CH*16-1:0]  rep_all;
    wire [CH*128-1:0] pat_all;
    wire [CH*7-1:0]   len_all;
    wire [7:0]        flag_all;                // level interrupt flags
    wire [7:0]        pulse_all;               // pulse interrupt strobes
    integer           k;

    wire       ext_rise = ext_s2_reg & ~ext_s3_reg;
    // a request is taken once, in the cycle waitrequest is still high
    wire       take     = (read_in | write_in) & wait_reg;
    // writes land at the edge waitrequest is sampled low
    wire       wr_go    = write_in & ~wait_reg;
    wire [2:0] ch_sel   = address_in[8:6];
    wire [5:0] ofs      = address_in[5:0];
    wire [31:0] bmask   = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
                           {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};

    assign readdata_out    = rdata_reg;
    assign waitrequest_out = wait_reg;
    assign irq_out         = irq_reg;

    // byte-lane merge of a write into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [31:0] m;
        begin
            merge = (old & ~m) | (wd & m);
        end
    endfunction

    // two flops before any logic sees the pin
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clk_in;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rdata_next = 32'h00000000;
        if (!address_in[9]) begin
            case (ofs)
                `OFS_CONTROL: rdata_next = ctrl_all[ch_sel*32 +: 32];
                // R4: buffer, not counter
                `OFS_RELOAD:  rdata_next = rel_all[ch_sel*32 +: 32];
                `OFS_COMPARE: rdata_next = cmp_all[ch_sel*32 +: 32];
                // R3: live counter value
                `OFS_OBSERVE: rdata_next = cnt_all[ch_sel*32 +: 32];
                `OFS_REPEAT:  rdata_next = {16'h0000, rep_all[ch_sel*16 +: 16]};
                // R9: word n holds pattern bits 32n+31..32n
                `OFS_PAT0:    rdata_next = pat_all[ch_sel*128 +: 32];
                `OFS_PAT1:    rdata_next = pat_all[ch_sel*128+32 +: 32];
                `OFS_PAT2:    rdata_next = pat_all[ch_sel*128+64 +: 32];
                `OFS_PAT3:    rdata_next = pat_all[ch_sel*128+96 +: 32];
                `OFS_PAT_LEN: rdata_next = {25'h0000000, len_all[ch_sel*7 +: 7]};
                default:      rdata_next = 32'h00000000;
            endcase
        end else begin
            case (address_in)
                `ADR_START:      rdata_next = {24'h000000, start_reg};
                `ADR_IRQ_STATUS: rdata_next = {24'h000000, flag_all};
                `ADR_PENDING_ID: rdata_next = {28'h0000000, id_reg};
                `ADR_REVISION:   rdata_next = REVISION;
                default:         rdata_next = 32'h00000000;
            endcase
        end
    end

    // avalon answer: waitrequest drops for one cycle, one edge after the request
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else if (take) begin
            wait_reg  <= 1'b0;
            rdata_reg <= read_in ? rdata_next : 32'h00000000;
        end else begin
            wait_reg  <= 1'b1;
        end
    end

    // lowest pending channel wins, reported as 1..8
    always @* begin
        id_next = 4'h0;
        for (k = 7; k >= 0; k = k - 1) begin
            if (flag_all[k]) begin
                id_next = k[3:0] + 4'h1;
            end
        end
    end

    // start register, pending id and combined interrupt
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            start_reg <= 8'h00;
            id_reg    <= 4'h0;
            irq_reg   <= 1'b0;
        end else begin
            if (wr_go && address_in == `ADR_START && byteenable_in[0]) begin
                start_reg <= writedata_in[7:0];
            end
            // R11: identify the interrupting timer
            id_reg  <= id_next;
            // R25: level flags or one-cycle pulses
            irq_reg <= (|flag_all) | (|pulse_all);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : chan
            localparam [2:0] IDX = g;
            reg  [31:0]  ctrl_reg;             // channel_control
            reg  [31:0]  rel_reg;              // reload_value_buffer
            reg  [31:0]  cmpb_reg;             // compare_value_buffer
            reg  [31:0]  cnt_reg;              // running counter
            reg  [31:0]  cmpw_reg;             // working compare value
            reg  [15:0]  rep_reg;              // repeat_count_buffer
            reg  [15:0]  left_reg;             // repeats still to run
            reg  [127:0] pat_reg;              // pattern words 0..3
            reg  [6:0]   len_reg;              // pattern_length
            reg  [6:0]   idx_reg;              // pattern bit position
            reg          halt_reg;             // counter stopped at zero without auto-reload
            reg          lvl_reg;              // compare-driven pwm level
            reg          out_reg;              // pwm_out
            reg          outn_reg;             // pwm_out_inverse
            reg          dzp_reg;              // pwm_out_gapped
            reg          dzn_reg;              // pwm_out_inverse_gapped
            reg  [7:0]   gap_reg;              // dead-zone countdown
            reg          req_reg;              // dma_request
            reg          flag_reg;             // irq_pending_flag
            reg          pulse_reg;            // pulse interrupt strobe

            wire       csel  = wr_go & ~address_in[9] & (ch_sel == IDX);
            wire [1:0] mode  = ctrl_reg[`CTL_MODE_HI:`CTL_MODE_LO];
            wire [7:0] dz    = ctrl_reg[`CTL_DZ_HI:`CTL_DZ_LO];
            wire       is_pat = (mode == `MODE_PATTERN);
            // R24: load request seen on write, never stored
            wire       upd   = csel & (ofs == `OFS_CONTROL) & byteenable_in[0]
                               & writedata_in[`CTL_LOAD_REQ];
            // R26: tick from bus clock or synchronised external edge
            wire       tick  = ctrl_reg[`CTL_CLK_SRC] ? ext_rise : 1'b1;
            wire       run   = start_reg[g] & ~halt_reg & tick;
            wire       zero  = run & (cnt_reg == 32'h00000000);
            wire       last  = is_pat ? (idx_reg == len_reg) : 1'b1;
            // R23: interval always reloads, repeat/pattern while count remains
            wire       autor = (mode == `MODE_INTERVAL)
                               | (mode[1] & (~last | (left_reg != 16'h0000)));
            wire       load  = upd | (zero & autor);
            // R8: repeat/pattern interrupt only at the end of the sequence
            wire       evt   = zero & (mode[1] ? ~autor : 1'b1);
            // R14: inverter forced off in pattern mode
            wire       raw   = ctrl_reg[`CTL_PWM_EN]
                               & (is_pat ? pat_reg[idx_reg]
                                         : lvl_reg ^ ctrl_reg[`CTL_INVERT]);

            assign ctrl_all[g*32 +: 32]   = ctrl_reg;
            assign rel_all[g*32 +: 32]    = rel_reg;
            assign cmp_all[g*32 +: 32]    = cmpb_reg;
            assign cnt_all[g*32 +: 32]    = cnt_reg;
            assign rep_all[g*16 +: 16]    = rep_reg;
            assign pat_all[g*128 +: 128]  = pat_reg;
            assign len_all[g*7 +: 7]      = len_reg;
            assign flag_all[g]            = flag_reg;
            assign pulse_all[g]           = pulse_reg;
            assign dma_request_out[g]        = req_reg;
            assign pwm_out[g]                = out_reg;
            assign pwm_out_inverse[g]        = outn_reg;
            assign pwm_out_gapped[g]         = dzp_reg;
            assign pwm_out_inverse_gapped[g] = dzn_reg;

            // software-visible buffers; observe offset has no write path
            always @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    ctrl_reg <= `RST_WORD;
                    rel_reg  <= `RST_WORD;
                    cmpb_reg <= `RST_WORD;
                    rep_reg  <= `RST_REPEAT;
                    pat_reg  <= {4{`RST_WORD}};
                    len_reg  <= `RST_PAT_LEN;
                end else if (csel) begin
                    case (ofs)
                        `OFS_CONTROL: ctrl_reg <= merge(ctrl_reg, writedata_in, bmask)
                                                  & `CTL_WRITE_MASK;
                        // R5: buffers only, the live period is untouched
                        `OFS_RELOAD:  rel_reg  <= merge(rel_reg, writedata_in, bmask);
                        // R15: compare may be rewritten mid-period
                        `OFS_COMPARE: cmpb_reg <= merge(cmpb_reg, writedata_in, bmask);
                        `OFS_REPEAT:  rep_reg  <= (rep_reg & ~bmask[15:0]) | (writedata_in[15:0] & bmask[15:0]);
                        `OFS_PAT0:    pat_reg[31:0]   <= merge(pat_reg[31:0], writedata_in, bmask);
                        `OFS_PAT1:    pat_reg[63:32]  <= merge(pat_reg[63:32], writedata_in, bmask);
                        `OFS_PAT2:    pat_reg[95:64]  <= merge(pat_reg[95:64], writedata_in, bmask);
                        `OFS_PAT3:    pat_reg[127:96] <= merge(pat_reg[127:96], writedata_in, bmask);
                        `OFS_PAT_LEN: begin
                            if (byteenable_in[0]) begin
                                len_reg <= writedata_in[6:0];
                            end
                        end
                        default: ;
                    endcase
                end
            end

            // counter, working compare, repeat and pattern sequencing
            always @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    cnt_reg  <= `RST_WORD;
                    cmpw_reg <= `RST_WORD;
                    left_reg <= `RST_REPEAT;
                    idx_reg  <= `RST_PAT_LEN;
                    halt_reg <= 1'b0;
                end else if (load) begin
                    // R1: counter takes the reload buffer
                    cnt_reg  <= rel_reg;
                    // R2: working compare takes the compare buffer
                    cmpw_reg <= cmpb_reg;
                    halt_reg <= 1'b0;
                    if (upd) begin
                        // R7: sequence runs rep_reg plus one times
                        left_reg <= rep_reg;
                        idx_reg  <= 7'h00;
                    end else begin
                        // R27: next pattern bit per period, wrap at length
                        if (is_pat) begin
                            idx_reg <= last ? 7'h00 : idx_reg + 7'h01;
                        end
                        // R10: one pass is length plus one bits
                        if (mode[1] && last) begin
                            left_reg <= left_reg - 16'h0001;
                        end
                    end
                end else if (zero) begin
                    // R6: no auto-reload, counter stops at zero
                    halt_reg <= 1'b1;
                end else if (run) begin
                    // R26: one step down per tick
                    cnt_reg <= cnt_reg - 32'h00000001;
                end
            end

            // pwm level, outputs and dead-zone gap
            always @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    lvl_reg  <= 1'b0;
                    out_reg  <= 1'b0;
                    outn_reg <= 1'b1;
                    dzp_reg  <= 1'b0;
                    dzn_reg  <= 1'b0;
                    gap_reg  <= 8'h00;
                end else begin
                    if (load) begin
                        // R12: low on every load event
                        lvl_reg <= 1'b0;
                    end else if (run && cnt_reg == cmpw_reg) begin
                        // R13: high on compare match
                        lvl_reg <= 1'b1;
                    end
                    out_reg  <= raw;
                    outn_reg <= ~raw;
                    if (dz <= 8'h01) begin
                        // R18: pass through without gap
                        dzp_reg <= raw;
                        dzn_reg <= ~raw;
                        gap_reg <= 8'h00;
                    end else if (raw != out_reg) begin
                        // R16: both off at every transition
                        dzp_reg <= 1'b0;
                        dzn_reg <= 1'b0;
                        // R17: gap of setting cycles on the bus clock, countdown from setting minus one
                        gap_reg <= dz - 8'h01;
                    end else if (gap_reg != 8'h00) begin
                        if (tick) begin
                            gap_reg <= gap_reg - 8'h01;
                        end
                    end else begin
                        dzp_reg <= out_reg;
                        dzn_reg <= outn_reg;
                    end
                end
            end

            // dma request and interrupt flags; set beats clear
            always @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    req_reg   <= 1'b0;
                    flag_reg  <= 1'b0;
                    pulse_reg <= 1'b0;
                end else begin
                    // R20: request at each count end
                    if (zero && ctrl_reg[`CTL_DMA_EN]) begin
                        req_reg <= 1'b1;
                    end else if (dma_acknowledge_in[g]) begin
                        // R21: acknowledge releases the request
                        req_reg <= 1'b0;
                    end
                    // R22: no interrupt while dma mode is on
                    pulse_reg <= evt & ~ctrl_reg[`CTL_DMA_EN] & ctrl_reg[`CTL_INT_EN]
                                 & ctrl_reg[`CTL_INT_PULSE];
                    // R25: level flag held until written one
                    if (evt && !ctrl_reg[`CTL_DMA_EN] && ctrl_reg[`CTL_INT_EN]
                        && !ctrl_reg[`CTL_INT_PULSE]) begin
                        flag_reg <= 1'b1;
                    end else if (wr_go && address_in == `ADR_IRQ_STATUS
                                 && byteenable_in[0] && writedata_in[g]) begin
                        flag_reg <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- src/pwm_timer_regs.vh ----
// register map, field positions and reset values of the pwm timer bank
`ifndef PWM_TIMER_REGS_VH
`define PWM_TIMER_REGS_VH

// per-channel byte offsets inside a 64-byte channel window
`define OFS_CONTROL      6'h00
`define OFS_RELOAD       6'h04
`define OFS_COMPARE      6'h08
`define OFS_OBSERVE      6'h0C
`define OFS_REPEAT       6'h10
`define OFS_PAT0         6'h14
`define OFS_PAT1         6'h18
`define OFS_PAT2         6'h1C
`define OFS_PAT3         6'h20
`define OFS_PAT_LEN      6'h24

// global registers, full byte address
`define ADR_START        10'h200
`define ADR_IRQ_STATUS   10'h204
`define ADR_PENDING_ID   10'h208
`define ADR_REVISION     10'h20C

// channel_control fields
`define CTL_CLK_SRC      0
`define CTL_LOAD_REQ     1
`define CTL_INVERT       2
`define CTL_MODE_HI      4
`define CTL_MODE_LO      3
`define CTL_INT_EN       5
`define CTL_INT_PULSE    6
`define CTL_DMA_EN       7
`define CTL_PWM_EN       8
`define CTL_DZ_HI        31
`define CTL_DZ_LO        24
`define CTL_WRITE_MASK   32'hFF0001FD

// run_mode_select encodings
`define MODE_ONE_SHOT    2'h0
`define MODE_INTERVAL    2'h1
`define MODE_REPEAT      2'h2
`define MODE_PATTERN     2'h3

// reset values
`define RST_WORD         32'h00000000
`define RST_REPEAT       16'h0000
`define RST_PAT_LEN      7'h00

`endif

// ---- test/pwm_timer_bank_assertions.sv ----
// protocol and output checks bound to the pwm timer bank
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_bank_assertions (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        read_in,
    input wire logic        write_in,
    input wire logic        waitrequest_out,
    input wire logic [7:0]  dma_acknowledge_in,
    input wire logic [7:0]  dma_request_out,
    input wire logic        irq_out,
    input wire logic [7:0]  pwm_out,
    input wire logic [7:0]  pwm_out_inverse,
    input wire logic [7:0]  pwm_out_gapped,
    input wire logic [7:0]  pwm_out_inverse_gapped
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // a taken request is answered exactly one cycle later
    a_wait_one_cycle: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("waitrequest not low one cycle after request");
    a_wait_single: assert property (!waitrequest_out |=> waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    a_wait_idle_high: assert property (!(read_in || write_in) |=> waitrequest_out)
        else $error("answer without a request");
    // request stands until the acknowledge arrives
    a_req_held_ack: assert property (dma_request_out[0] && !dma_acknowledge_in[0] |=> dma_request_out[0])
        else $error("dma request dropped without acknowledge");
    a_gap_never_both: assert property ((pwm_out_gapped & pwm_out_inverse_gapped) == 8'h00)
        else $error("gapped outputs high together");
    a_raw_inverse_pair: assert property (pwm_out_inverse == ~pwm_out)
        else $error("raw inverse output not complement");
    a_true_rise_cause: assert property ($rose(pwm_out_gapped[0]) |-> pwm_out[0])
        else $error("gapped true output rose while raw low");
    a_inv_rise_cause: assert property ($rose(pwm_out_inverse_gapped[0]) |-> pwm_out_inverse[0])
        else $error("gapped inverse output rose while raw high");
    c_dma_request: cover property ($rose(dma_request_out[0]));
    c_irq_raised: cover property ($rose(irq_out));
    c_gap_rise: cover property ($rose(pwm_out_gapped[0]));
endmodule
bind pwm_timer_bank pwm_timer_bank_assertions checker_i (.clock_in(clock_in), .rst_in(rst_in),
    .read_in(read_in), .write_in(write_in), .waitrequest_out(waitrequest_out),
    .dma_acknowledge_in(dma_acknowledge_in), .dma_request_out(dma_request_out), .irq_out(irq_out),
    .pwm_out(pwm_out), .pwm_out_inverse(pwm_out_inverse), .pwm_out_gapped(pwm_out_gapped),
    .pwm_out_inverse_gapped(pwm_out_inverse_gapped));
`default_nettype wire

// ---- test/dma_ack_model.sv ----
// dma controller side: acknowledges each request after a delay
`timescale 1ns/1ps
`default_nettype none
module dma_ack_model #(
    parameter DELAY = 3              // cycles a request waits minus one, slow answer
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] request_in,
    output var  logic [7:0] ack_out
);
    logic [3:0] wait_reg [8];        // per-channel wait counter
    // ack pulses once per standing request
    always @(posedge clock_in or posedge rst_in) begin
        for (int i = 0; i < 8; i++) begin
            if (rst_in) begin
                wait_reg[i] <= 4'h0;
                ack_out[i]  <= 1'b0;
            end else if (request_in[i] && !ack_out[i] && wait_reg[i] == DELAY) begin
                ack_out[i]  <= 1'b1;
                wait_reg[i] <= 4'h0;
            end else begin
                ack_out[i]  <= 1'b0;
                wait_reg[i] <= (request_in[i] && !ack_out[i]) ? wait_reg[i] + 4'h1 : 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the pwm timer bank
`include "pwm_timer_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam [31:0] REV = 32'h0000005A;  // arbitrary revision value
    logic clock_in, rst_in, read_in, write_in, ext_clk_in, waitrequest_out, irq_out;
    logic [9:0]  address_in;
    logic [31:0] writedata_in, readdata_out, rd;
    logic [3:0]  byteenable_in;
    logic [7:0]  dma_acknowledge_in, dma_request_out, pwm_out, pwm_out_inverse, pwm_out_gapped, pwm_out_inverse_gapped;
    int fail_count = 0;
    int comparisons = 0;
    pwm_timer_bank #(.REVISION(REV)) pwm_timer_bank_i (.clock_in(clock_in), .rst_in(rst_in),
        .address_in(address_in), .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
        .byteenable_in(byteenable_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .ext_clk_in(ext_clk_in), .dma_acknowledge_in(dma_acknowledge_in), .dma_request_out(dma_request_out),
        .irq_out(irq_out), .pwm_out(pwm_out), .pwm_out_inverse(pwm_out_inverse),
        .pwm_out_gapped(pwm_out_gapped), .pwm_out_inverse_gapped(pwm_out_inverse_gapped));
    dma_ack_model dma_ack_model_i (.clock_in(clock_in), .rst_in(rst_in), .request_in(dma_request_out),
        .ack_out(dma_acknowledge_in));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clock_in);
        read_in <= !wr; write_in <= wr; address_in <= a; writedata_in <= d;
        do begin @(posedge clock_in); n++; end while (waitrequest_out !== 1'b0 && n < 40);
        rd = readdata_out;
        read_in <= 1'b0; write_in <= 1'b0;
        if (n >= 40) begin fail_count++; test_done(); end
    endtask
    task automatic cyc(input int n); repeat (n) @(posedge clock_in); endtask
    // reset values, read-only and unmapped places
    task automatic s_regs;
        acc(0, `OFS_RELOAD, 0); chk(rd, `RST_WORD);
        acc(0, `ADR_REVISION, 0); chk(rd, REV);
        acc(0, 10'h3F0, 0); chk(rd, 32'h00000000);
        acc(0, `ADR_PENDING_ID, 0); chk(rd, 32'h00000000);
    endtask
    // one-shot: load, live count, halt at zero
    task automatic s_one_shot;
        acc(1, `OFS_RELOAD, 32'h00000005); acc(1, `OFS_CONTROL, 32'h00000002);
        acc(0, `OFS_OBSERVE, 0); chk(rd, 32'h00000005);
        acc(1, `OFS_OBSERVE, 32'h00000077); acc(0, `OFS_OBSERVE, 0); chk(rd, 32'h00000005);
        acc(0, `OFS_CONTROL, 0); chk(rd, 32'h00000000);
        acc(1, `ADR_START, 32'h00000001); cyc(30);
        acc(0, `OFS_OBSERVE, 0); chk(rd, 32'h00000000);
        acc(0, `OFS_RELOAD, 0); chk(rd, 32'h00000005);
    endtask
    // dma pacing: requests flow, interrupt stays quiet
    task automatic s_dma;
        int reqs = 0;
        int irqs = 0;
        acc(1, `OFS_RELOAD, 32'h00000003); acc(1, `OFS_CONTROL, 32'h000000AA);
        for (int i = 0; i < 60; i++) begin
            @(posedge clock_in);
            if (dma_request_out[0] === 1'b1) reqs++;
            if (irq_out !== 1'b0) irqs++;
        end
        acc(1, `ADR_START, 32'h00000000);
        chk(reqs > 0, 1);
        chk(irqs, 0);
    endtask
    // level interrupt, id, write-one clear
    task automatic s_irq;
        int n = 0;
        acc(1, 10'h080 + `OFS_RELOAD, 32'h00000002); acc(1, 10'h080 + `OFS_CONTROL, 32'h00000022);
        acc(1, `ADR_START, 32'h00000004);
        while (irq_out !== 1'b1 && n < 50) begin @(posedge clock_in); n++; end
        chk(irq_out, 1);
        if (n >= 50) test_done();
        acc(0, `ADR_PENDING_ID, 0); chk(rd, 32'h00000003);
        acc(1, `ADR_IRQ_STATUS, 32'h00000004); cyc(3);
        chk(irq_out, 0);
    endtask
    // duty from reload and compare with the inverter off, then inverted with gap
    task automatic high_count(output int h, output int g);
        h = 0; g = 0;
        for (int i = 0; i < 100; i++) begin
            @(posedge clock_in);
            if (pwm_out[0] === 1'b1) h++;
            if (pwm_out_gapped[0] === 1'b1) g++;
        end
    endtask
    task automatic s_pwm;
        int h, g;
        acc(1, `OFS_RELOAD, 32'h00000009); acc(1, `OFS_COMPARE, 32'h00000002);
        acc(1, `OFS_CONTROL, 32'h0000010A); acc(1, `ADR_START, 32'h00000001);
        cyc(30); high_count(h, g); chk(h, 20);
        acc(1, `OFS_COMPARE, 32'h00000006); high_count(h, g); chk(h, 56);
        acc(1, `OFS_CONTROL, 32'h0300010E);
        cyc(30); high_count(h, g); chk(h, 40);
        chk(g, 10);
    endtask
    initial begin
        rst_in = 1'b1; read_in = 1'b0; write_in = 1'b0; address_in = 10'h000;
        writedata_in = 32'h00000000; byteenable_in = 4'hF; ext_clk_in = 1'b0;
        cyc(4);
        rst_in <= 1'b0;
        s_regs(); s_one_shot(); s_dma(); s_irq(); s_pwm();
        test_done();
    end
endmodule
`default_nettype wire
